// >>> rtl/iclk_pkg.sv
// Package of constants and types for the internal clock select and tune block
package iclk_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int MF_PERIOD_NS = 2000;
   localparam int LF_PERIOD_NS = 32258;
   localparam int WARM_NS = 2000;
   localparam int LOCK_NS = 4000;
   localparam int STABLE_NS = 8000;
   localparam int TRIM_STEP_NS = 1000;
   localparam int MF_DIV_CYC = MF_PERIOD_NS / CLK_PERIOD_NS;
   localparam int LF_DIV_CYC = LF_PERIOD_NS / CLK_PERIOD_NS;
   localparam int WARM_CYC = (WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCK_CYC = (LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STABLE_CYC = (STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRIM_STEP_CYC = (TRIM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_STAT = 2'h1;
   localparam logic [1:0] ADDR_TRIM = 2'h2;
   localparam int CTRL_SCS_LSB = 0;
   localparam int CTRL_FSEL_LSB = 3;
   localparam int CTRL_SMULT_BIT = 7;
   localparam logic [3:0] FSEL_RESET = 4'h7;
   localparam logic [1:0] SCS_RESET = 2'h0;
   localparam logic [5:0] TRIM_RESET = 6'h00;
   localparam logic [3:0] FSEL_X4 = 4'hE;
   localparam logic [2:0] CFG_INTERNAL_OSC_BLOCK = 3'h4;
   localparam logic [2:0] CFG_EXT_RC = 3'h3;
   localparam logic [1:0] SCS_CONFIG = 2'h0;
   localparam logic [1:0] SCS_TIMER1 = 2'h1;

   typedef enum logic [1:0] {
      ICLK_SRC_LF = 2'b00,
      ICLK_SRC_MF = 2'b01,
      ICLK_SRC_HF = 2'b10
   } iclk_src_t;

endpackage

// >>> rtl/iclk_tick_div.sv
// Programmable tick divider standing in for an oscillator or postscaler
`timescale 1ns/1ps
module iclk_tick_div #(
   parameter int W = 12
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic step,
   input wire logic [W-1:0] period,
   output logic tick
);
   logic [W-1:0] cnt_q;

   // Counts steps; tick is one cycle on the step that ends a period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (!run) begin
         cnt_q <= '0;
      end else if (step) begin
         if (cnt_q >= period - W'(1)) begin
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_q + W'(1);
         end
      end
   end

   assign tick = run && step && (cnt_q >= period - W'(1));
endmodule // iclk_tick_div

// >>> rtl/iclk_startup.sv
// Start-up tracker that raises ready, locked and stable in turn
`timescale 1ns/1ps
module iclk_startup #(
   parameter int READY_CYC = 80,
   parameter int LOCK_CYC = 160,
   parameter int STABLE_CYC = 320
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic en,
   output logic ready,
   output logic locked,
   output logic stable
);
   localparam int CW = $clog2(STABLE_CYC + 1);
   logic [CW-1:0] cnt_q;

   // Restarts from zero whenever the source is switched off
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (!en) begin
         cnt_q <= '0;
      end else if (cnt_q != CW'(STABLE_CYC)) begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   assign ready = en && (cnt_q >= CW'(READY_CYC));
   assign locked = en && (cnt_q >= CW'(LOCK_CYC));
   assign stable = en && (cnt_q >= CW'(STABLE_CYC));
endmodule // iclk_startup

// >>> rtl/iclk_ctrl.sv
// Internal clock source selection, tuning and status block
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module iclk_ctrl
   import iclk_pkg::*;
#(
   parameter int MF_DIV = MF_DIV_CYC,
   parameter int LF_DIV = LF_DIV_CYC,
   parameter int WARM = WARM_CYC,
   parameter int LOCK = LOCK_CYC,
   parameter int STABLE = STABLE_CYC,
   parameter int TRIM_STEP = TRIM_STEP_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] osc_config_select,
   input wire logic clock_out_enable_cfg,
   input wire logic cfg_multiplier_enable,
   input wire logic lf_demand,
   input wire logic ext_clk_tick,
   input wire logic t1_clk_tick,
   input wire logic osc_output_pin_i,
   output logic osc_output_pin_o,
   output logic osc_output_pin_oe_n,
   input wire logic gpio2_out,
   input wire logic gpio2_oe_n,
   output logic gpio2_in,
   output logic osc_input_pin_released,
   output logic lf_clk_tick,
   output logic sys_clk_tick,
   output logic x4_engaged,
   output logic [5:0] trim_applied
);

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic iclk_src_t src_of(input logic [3:0] code);
      if (code[3:1] == 3'h0) begin
         src_of = ICLK_SRC_LF;
      end else if (code == 4'h2 || (code >= 4'h4 && code <= 4'h7)) begin
         src_of = ICLK_SRC_MF;
      end else begin
         src_of = ICLK_SRC_HF;
      end
   endfunction

   // Postscaler as a power of two below the chosen source
   function automatic logic [3:0] shift_of(input logic [3:0] code);
      if (code[3:1] == 3'h0) begin
         shift_of = 4'h0;
      end else if (code == 4'h2) begin
         shift_of = 4'h4;
      end else if (code == 4'h3) begin
         shift_of = 4'h9;
      end else if (code <= 4'h7) begin
         shift_of = 4'h7 - code;
      end else begin
         shift_of = 4'hF - code;
      end
   endfunction

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [3:0] fsel_q;
   logic [1:0] scs_q;
   logic smult_q;
   logic [5:0] trim_q;
   logic [5:0] trim_app_q;
   logic [$clog2(TRIM_STEP + 1)-1:0] trim_cnt_q;
   logic [7:0] rdata_q;
   logic [7:0] status;
   logic hf_ready, hf_locked, hf_stable, mf_ready, lf_ready;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fsel_q <= FSEL_RESET;
         scs_q <= SCS_RESET;
         smult_q <= 1'b0;
      end else if (reg_wr && reg_addr == ADDR_CTRL) begin
         fsel_q <= reg_wdata[CTRL_FSEL_LSB +: 4];
         scs_q <= reg_wdata[CTRL_SCS_LSB +: 2];
         smult_q <= reg_wdata[CTRL_SMULT_BIT];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trim_q <= TRIM_RESET;
      end else if (reg_wr && reg_addr == ADDR_TRIM) begin
         trim_q <= reg_wdata[5:0];
      end
   end

   // Applied trim walks one step at a time toward the written value
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trim_app_q <= TRIM_RESET;
         trim_cnt_q <= '0;
      end else if (trim_app_q == trim_q) begin
         trim_cnt_q <= '0;
      end else if (trim_cnt_q == ($bits(trim_cnt_q))'(TRIM_STEP - 1)) begin
         trim_cnt_q <= '0;
         if ($signed(trim_q) > $signed(trim_app_q)) begin
            trim_app_q <= trim_app_q + 6'h01;
         end else begin
            trim_app_q <= trim_app_q - 6'h01;
         end
      end else begin
         trim_cnt_q <= trim_cnt_q + 1'b1;
      end
   end

   assign status = {2'h0, x4_engaged, hf_ready, hf_locked, mf_ready, lf_ready, hf_stable};

   // No status bit reports the trim walk; software cannot see it finish
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CTRL: rdata_q <= {smult_q, fsel_q, 1'b0, scs_q};
            ADDR_STAT: rdata_q <= status;
            ADDR_TRIM: rdata_q <= {2'h0, trim_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata = rdata_q;

   // ----------------------------------------------------------------
   // Source enables and start-up
   // ----------------------------------------------------------------
   logic internal_osc_block_cfg, int_path, hf_en, mf_en, lf_en, mf_run;
   iclk_src_t req_src;

   assign internal_osc_block_cfg = (osc_config_select == CFG_INTERNAL_OSC_BLOCK);
   assign int_path = internal_osc_block_cfg || scs_q[1];
   assign req_src = src_of(fsel_q);
   assign hf_en = (req_src == ICLK_SRC_HF) && int_path;
   assign mf_en = (req_src == ICLK_SRC_MF) && int_path;
   // The medium oscillator also feeds the lock loop, so it runs under the high source
   assign mf_run = mf_en || hf_en;
   assign lf_en = ((req_src == ICLK_SRC_LF) && int_path) || lf_demand;

   logic mf_base_ready;

   iclk_startup #(.READY_CYC(WARM), .LOCK_CYC(WARM), .STABLE_CYC(WARM)) u_mf_start (
      .clk(clk),
      .rst(rst),
      .en(mf_run),
      .ready(mf_base_ready),
      .locked(),
      .stable()
   );

   // Lock loop only starts once its medium reference is up
   iclk_startup #(.READY_CYC(WARM), .LOCK_CYC(LOCK), .STABLE_CYC(STABLE)) u_hf_start (
      .clk(clk),
      .rst(rst),
      .en(hf_en && mf_base_ready),
      .ready(hf_ready),
      .locked(hf_locked),
      .stable(hf_stable)
   );

   iclk_startup #(.READY_CYC(WARM), .LOCK_CYC(WARM), .STABLE_CYC(WARM)) u_lf_start (
      .clk(clk),
      .rst(rst),
      .en(lf_en),
      .ready(lf_ready),
      .locked(),
      .stable()
   );

   assign mf_ready = mf_en && mf_base_ready;

   // ----------------------------------------------------------------
   // Oscillator stand-ins
   // ----------------------------------------------------------------
   logic mf_tick, hf_tick;
   logic [11:0] mf_period;

   // Positive trim shortens the base period; the low source never sees it
   assign mf_period = 12'(MF_DIV) - {{6{trim_app_q[5]}}, trim_app_q};
   assign trim_applied = trim_app_q;

   iclk_tick_div #(.W(12)) u_mf_osc (
      .clk(clk),
      .rst(rst),
      .run(mf_base_ready),
      .step(1'b1),
      .period(mf_period),
      .tick(mf_tick)
   );

   // High source rate exceeds the model clock, so it ticks every cycle
   assign hf_tick = hf_ready;

   iclk_tick_div #(.W(12)) u_lf_osc (
      .clk(clk),
      .rst(rst),
      .run(lf_ready),
      .step(1'b1),
      .period(12'(LF_DIV)),
      .tick(lf_clk_tick)
   );

   // ----------------------------------------------------------------
   // Source switch and postscaler
   // ----------------------------------------------------------------
   iclk_src_t cur_src_q;
   logic [3:0] cur_shift_q;
   logic tgt_ready, src_tick, int_tick, mult_on;
   logic [11:0] post_period;

   always_comb begin
      unique case (req_src)
         ICLK_SRC_LF: tgt_ready = lf_ready;
         ICLK_SRC_MF: tgt_ready = mf_ready;
         ICLK_SRC_HF: tgt_ready = hf_ready;
         default: tgt_ready = 1'b0;
      endcase
   end

   // Same-source code changes take effect at once; a new source waits for ready
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur_src_q <= ICLK_SRC_MF;
         cur_shift_q <= 4'h0;
      end else if (req_src == cur_src_q) begin
         cur_shift_q <= shift_of(fsel_q);
      end else if (tgt_ready) begin
         cur_src_q <= req_src;
         cur_shift_q <= shift_of(fsel_q);
      end
   end

   always_comb begin
      unique case (cur_src_q)
         ICLK_SRC_LF: src_tick = lf_clk_tick;
         ICLK_SRC_MF: src_tick = mf_tick;
         ICLK_SRC_HF: src_tick = hf_tick;
         default: src_tick = 1'b0;
      endcase
   end

   assign mult_on = cfg_multiplier_enable || smult_q;
   // x4 only with config 100, select 00 and code 1110
   assign x4_engaged = mult_on && internal_osc_block_cfg && (scs_q == SCS_CONFIG)
                       && (fsel_q == FSEL_X4) && hf_ready;
   // Configured multiplier removes plain 8 MHz: the code then runs undivided
   assign post_period = (x4_engaged || (cfg_multiplier_enable && fsel_q == FSEL_X4))
                        ? 12'h001 : (12'h001 << cur_shift_q);

   iclk_tick_div #(.W(12)) u_post (
      .clk(clk),
      .rst(rst),
      .run(1'b1),
      .step(src_tick),
      .period(post_period),
      .tick(int_tick)
   );

   always_comb begin
      if (scs_q[1]) begin
         sys_clk_tick = int_tick;
      end else if (scs_q == SCS_TIMER1) begin
         sys_clk_tick = t1_clk_tick;
      end else if (internal_osc_block_cfg) begin
         sys_clk_tick = int_tick;
      end else begin
         sys_clk_tick = ext_clk_tick;
      end
   end

   // ----------------------------------------------------------------
   // Oscillator pins
   // ----------------------------------------------------------------
   logic clkout_q, pin_free, clkout_mode;

   // Clock output toggles on each system tick, a half-rate view of it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clkout_q <= 1'b0;
      end else if (sys_clk_tick) begin
         clkout_q <= ~clkout_q;
      end
   end

   assign pin_free = internal_osc_block_cfg || (osc_config_select == CFG_EXT_RC);
   assign clkout_mode = pin_free && clock_out_enable_cfg;
   assign osc_output_pin_o = clkout_mode ? clkout_q : gpio2_out;
   assign osc_output_pin_oe_n = clkout_mode ? 1'b0 : (pin_free ? gpio2_oe_n : 1'b1);
   assign gpio2_in = (pin_free && !clock_out_enable_cfg) ? osc_output_pin_i : 1'b0;
   assign osc_input_pin_released = internal_osc_block_cfg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_HF_ENABLE: assert property (@(posedge clk) disable iff (rst)
      hf_ready |-> (req_src == ICLK_SRC_HF) && int_path)
      else $error("high source ready while not enabled");

   AST_HF_NEEDS_MF: assert property (@(posedge clk) disable iff (rst)
      hf_ready |-> mf_base_ready)
      else $error("high source running without medium reference");

   AST_FLAG_ORDER: assert property (@(posedge clk) disable iff (rst)
      hf_stable |-> hf_locked && hf_ready)
      else $error("stable flag ahead of locked or ready");

   AST_FLAG_OFF: assert property (@(posedge clk) disable iff (rst)
      $rose(mf_run) |-> !mf_base_ready)
      else $error("medium ready at once on restart");

   AST_LF_READY: assert property (@(posedge clk) disable iff (rst)
      $rose(lf_en) |-> !lf_ready [*8])
      else $error("low ready rose without warm-up");

   AST_TRIM_STEP: assert property (@(posedge clk) disable iff (rst)
      (trim_app_q != $past(trim_app_q)) |->
         (trim_app_q - $past(trim_app_q) == 6'h01) || ($past(trim_app_q) - trim_app_q == 6'h01))
      else $error("trim moved by more than one step");

   AST_TRIM_WRITE_SLOW: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == ADDR_TRIM && reg_wdata[5:0] != trim_app_q
       && trim_app_q == trim_q) |=>
         $stable(trim_app_q))
      else $error("trim applied at once");

   AST_X4_SCS: assert property (@(posedge clk) disable iff (rst)
      scs_q[1] |-> !x4_engaged)
      else $error("multiplier engaged with select 1x");

   AST_CFG_MULT: assert property (@(posedge clk) disable iff (rst)
      (cfg_multiplier_enable && internal_osc_block_cfg && scs_q == SCS_CONFIG && fsel_q == FSEL_X4
       && hf_ready) |-> x4_engaged)
      else $error("configured multiplier not forced on");

   AST_SAME_SRC: assert property (@(posedge clk) disable iff (rst)
      (req_src == cur_src_q) |=> (cur_shift_q == $past(shift_of(fsel_q))))
      else $error("same-source change not taken in one cycle");

   AST_RDATA: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == ADDR_CTRL) |=> reg_rdata[6:3] == $past(fsel_q))
      else $error("control read does not show frequency select");

   AST_PIN_GPIO: assert property (@(posedge clk) disable iff (rst)
      (pin_free && !clock_out_enable_cfg) |-> osc_output_pin_oe_n == gpio2_oe_n)
      else $error("second pin not handed to general I/O");

endmodule // iclk_ctrl

// >>> bench/iclk_ctrl_tb_top.sv
// Self-checking testbench for the internal clock select and tune block
`timescale 1ns/1ps
module iclk_ctrl_tb_top;
   import iclk_pkg::*;

   // ----------------------------------------------------------------
   // Stimulus and observation
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [2:0] cfg_sel = 3'h4;
   logic clkout_cfg = 1'b0;
   logic cfg_mult = 1'b0;
   logic lf_demand = 1'b0;
   logic pin_i = 1'b0;
   logic pin_o;
   logic pin_oe_n;
   logic ext_tick = 1'b0;
   logic t1_tick = 1'b0;
   logic gpio2_out = 1'b0;
   logic gpio2_oe_n = 1'b1;
   logic gpio2_in;
   logic released;
   logic lf_tick;
   logic sys_tick;
   logic x4_on;
   logic [5:0] trim_applied;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;

   always #12.5 clk = ~clk;

   // Short counts keep every start-up inside a few hundred cycles
   // Medium divider keeps its default so the measured periods follow the package
   iclk_ctrl #(.LF_DIV(20), .WARM(8), .LOCK(12), .STABLE(16), .TRIM_STEP(2)) dut (
      .clk(clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .osc_config_select(cfg_sel),
      .clock_out_enable_cfg(clkout_cfg),
      .cfg_multiplier_enable(cfg_mult),
      .lf_demand(lf_demand),
      .ext_clk_tick(ext_tick),
      .t1_clk_tick(t1_tick),
      .osc_output_pin_i(pin_i),
      .osc_output_pin_o(pin_o),
      .osc_output_pin_oe_n(pin_oe_n),
      .gpio2_out(gpio2_out),
      .gpio2_oe_n(gpio2_oe_n),
      .gpio2_in(gpio2_in),
      .osc_input_pin_released(released),
      .lf_clk_tick(lf_tick),
      .sys_clk_tick(sys_tick),
      .x4_engaged(x4_on),
      .trim_applied(trim_applied)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic poll(input logic [7:0] mask, input logic [7:0] want);
      logic [7:0] s;
      s = 8'h00;
      for (int n = 0; n < 100; n++) begin
         rd(ADDR_STAT, s);
         if ((s & mask) === want) break;
      end
      chk("status", want, s & mask);
   endtask

   task automatic settle();
      @(posedge clk);
      #1;
   endtask

   // Cycles from one system tick to the next, sampled after each edge settles
   task automatic gap_sys(input string what, input int exp);
      int n;
      n = 0;
      for (int k = 0; k < 400; k++) begin
         @(posedge clk);
         #1;
         if (sys_tick === 1'b1) break;
      end
      for (int k = 0; k < 400; k++) begin
         @(posedge clk);
         #1;
         n++;
         if (sys_tick === 1'b1) break;
      end
      chk(what, exp[7:0], n[7:0]);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_defaults();
      logic [7:0] d;
      rd(ADDR_CTRL, d);
      chk("ctrl reset", 8'h38, d);
      rd(ADDR_TRIM, d);
      chk("trim reset", 8'h00, d);
      wr(2'h3, 8'hFF);
      rd(2'h3, d);
      chk("unmapped", 8'h00, d);
      rd(ADDR_CTRL, d);
      chk("ctrl kept", 8'h38, d);
      $display("test defaults done");
   endtask

   task automatic t_sources();
      poll(8'h04, 8'h04);
      wr(ADDR_CTRL, 8'h02);
      poll(8'h06, 8'h02);
      wr(ADDR_CTRL, 8'h7A);
      poll(8'h19, 8'h19);
      gap_sys("hf undivided", 1);
      wr(ADDR_CTRL, 8'h62);
      gap_sys("hf by 8", 8);
      $display("test sources done");
   endtask

   task automatic t_multiplier();
      wr(ADDR_CTRL, 8'hF0);
      poll(8'h30, 8'h30);
      chk("x4 on", 8'h01, {7'h0, x4_on});
      wr(ADDR_CTRL, 8'hF2);
      poll(8'h20, 8'h00);
      chk("x4 off in 1x", 8'h00, {7'h0, x4_on});
      cfg_mult <= 1'b1;
      wr(ADDR_CTRL, 8'h70);
      poll(8'h20, 8'h20);
      chk("x4 forced", 8'h01, {7'h0, x4_on});
      cfg_mult <= 1'b0;
      wr(ADDR_CTRL, 8'h70);
      poll(8'h20, 8'h00);
      $display("test multiplier done");
   endtask

   task automatic wait_trim(input logic [5:0] exp);
      for (int n = 0; n < 300; n++) begin
         @(posedge clk);
         #1;
         if (trim_applied === exp) break;
      end
      #1 chk("trim applied", {2'b00, exp}, {2'b00, trim_applied});
   endtask

   // Low-source ticks over 100 cycles must not move with the trim
   task automatic count_lf();
      int n;
      n = 0;
      repeat (100) begin
         @(posedge clk);
         #1 if (lf_tick === 1'b1) n++;
      end
      chk("lf ticks", 8'h05, n[7:0]);
   endtask

   task automatic t_trim();
      logic [7:0] d;
      lf_demand <= 1'b1;
      wr(ADDR_CTRL, 8'h38);
      poll(8'h02, 8'h02);
      count_lf();
      gap_sys("mf period", MF_DIV_CYC);
      wr(ADDR_TRIM, 8'h1F);
      #1 chk("trim gradual", 8'h01, {7'h0, trim_applied !== 6'h1F});
      rd(ADDR_TRIM, d);
      chk("trim max", 8'h1F, d);
      wait_trim(6'h1F);
      gap_sys("mf period fast", MF_DIV_CYC - 31);
      count_lf();
      wr(ADDR_TRIM, 8'hE0);
      rd(ADDR_TRIM, d);
      chk("trim min", 8'h20, d);
      wait_trim(6'h20);
      gap_sys("mf period slow", MF_DIV_CYC + 32);
      count_lf();
      lf_demand <= 1'b0;
      $display("test trim done");
   endtask

   task automatic t_pins();
      @(posedge clk);
      clkout_cfg <= 1'b0;
      gpio2_out <= 1'b1;
      gpio2_oe_n <= 1'b0;
      pin_i <= 1'b1;
      settle();
      chk("pin io oe", 8'h00, {7'h0, pin_oe_n});
      chk("pin io out", 8'h01, {7'h0, pin_o});
      chk("pin io in", 8'h01, {7'h0, gpio2_in});
      chk("in pin free", 8'h01, {7'h0, released});
      gpio2_oe_n <= 1'b1;
      settle();
      chk("pin io hiz", 8'h01, {7'h0, pin_oe_n});
      clkout_cfg <= 1'b1;
      settle();
      chk("pin clkout oe", 8'h00, {7'h0, pin_oe_n});
      cfg_sel <= CFG_EXT_RC;
      settle();
      chk("in pin used", 8'h00, {7'h0, released});
      wr(ADDR_CTRL, 8'h78);
      poll(8'h1D, 8'h00);
      ext_tick <= 1'b1;
      settle();
      chk("sys from config", 8'h01, {7'h0, sys_tick});
      wr(ADDR_CTRL, 8'h79);
      settle();
      chk("sys from timer idle", 8'h00, {7'h0, sys_tick});
      t1_tick <= 1'b1;
      settle();
      chk("sys from timer", 8'h01, {7'h0, sys_tick});
      ext_tick <= 1'b0;
      t1_tick <= 1'b0;
      cfg_sel <= CFG_INTERNAL_OSC_BLOCK;
      clkout_cfg <= 1'b0;
      $display("test pins done");
   endtask

   task automatic t_rereset();
      logic [7:0] d;
      wr(ADDR_CTRL, 8'h7A);
      wr(ADDR_TRIM, 8'h05);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_CTRL, d);
      chk("ctrl rereset", 8'h38, d);
      rd(ADDR_TRIM, d);
      chk("trim rereset", 8'h00, d);
      $display("test rereset done");
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_defaults();
      t_sources();
      t_multiplier();
      t_trim();
      t_pins();
      t_rereset();
      complete_run();
   end
endmodule // iclk_ctrl_tb_top
